// [ckg_pkg.sv]
// Purpose: shared constants and carriers for the clock generation control block
// Assumes: 8-bit register data, 16-bit register address
// Notes: clk of the block stands for the master clock domain
package ckg_pkg;
	// ==========================================
	// Register map
	localparam logic [15:0] MASTER_CLOCK_CONTROL_OFS = 16'h008F;
	localparam logic [15:0] CPU_CLOCK_DIVIDER_OFS = 16'hFFA1;
	localparam logic [7:0] MASTER_CLOCK_CONTROL_RST = 8'h0A;
	localparam logic [5:0] CPU_DIVIDER_FIELD_RST = 6'h0C;
	// ==========================================
	// Field positions in master_clock_control
	localparam int FAST_OSC_DISABLE_BIT = 7;
	localparam int KEYPAD_CLOCK_GATE_BIT = 6;
	localparam int CARD_CLOCK_GATE_BIT = 5;
	localparam int SERIAL_BUS_CLOCK_GATE_BIT = 4;
	localparam int SLOW_OSC_DISABLE_BIT = 3;
	localparam int VCO_MULTIPLIER_LSB = 0;
	localparam int VCO_MULTIPLIER_W = 3;
	localparam int CPU_DIVIDER_W = 6;
	// ==========================================
	// Timing
	localparam int MASTER_CLOCK_HZ = 96000000;
	localparam int SLOW_CLOCK_HZ = 32768;
	localparam int SLOW_HALF_CYCLES = MASTER_CLOCK_HZ / (2 * SLOW_CLOCK_HZ);
	// ==========================================
	// Carriers
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ckg_req_t;
	typedef struct packed {
		logic [7:0] mclk_ctl;
		logic [5:0] cpu_div;
		logic [5:0] div_cnt;
		logic cpu_clk;
		logic [15:0] slow_cnt;
		logic slow_clk;
		logic [7:0] rdata;
	} ckg_state_t;
endpackage

// [ckg_clock_control.sv]
// Purpose: master clock ratio, peripheral clock gates, cpu divider, slow clock source
// Assumes: clk is the master clock; register strobes are one cycle long
// Notes: read data stands in the cycle after the read strobe only
`timescale 1ns/1ps
// Behaviour
// - Master clock ratio to crystal is twice the multiplier plus four.
// - Master clock runs at 96 MHz for peripherals that need it.
// - Top bit disables fast oscillator and loop; software never sets it.
// - Bits six, five, four stop keypad, card, serial bus clocks.
// - Slow-oscillator disable selects derived 32 kHz clock and stops oscillator.
// - Master clock register resets to 0x0A, multiplier two.
// - Cpu clock is master clock over twice the divider field plus two.
// - Divider register resets to 0x0C.
// - Cpu clock is driven onto a dedicated output pin.
module ckg_clock_control #(
	parameter int SLOW_HALF = ckg_pkg::SLOW_HALF_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire ckg_pkg::ckg_req_t req,
	output logic [7:0] rdata,
	output logic [4:0] vco_ratio,
	output logic fast_osc_off,
	output logic keypad_clk_en,
	output logic card_clk_en,
	output logic serial_bus_clk_en,
	output logic slow_osc_run,
	output logic slow_from_main,
	output logic slow_clk,
	output logic cpu_clock,
	output logic core_clock_out_pin
);
	import ckg_pkg::*;

	// ==========================================
	// Parameter check
	if (SLOW_HALF < 1 || SLOW_HALF > 65535) begin : g_bad
		$error("SLOW_HALF out of range");
	end
	if (VCO_MULTIPLIER_LSB + VCO_MULTIPLIER_W > SLOW_OSC_DISABLE_BIT) begin : g_bad_fields
		$error("multiplier field overlaps slow oscillator bit");
	end
	if (CPU_DIVIDER_W != 6) begin : g_bad_div
		$error("divider counter is built for a six-bit field");
	end

	localparam logic [15:0] SLOW_LAST = 16'(SLOW_HALF - 1);

	ckg_state_t st_q;
	ckg_state_t st_d;
	logic [2:0] mult;

	assign mult = st_q.mclk_ctl[VCO_MULTIPLIER_LSB +: VCO_MULTIPLIER_W];

	// ==========================================
	// Next state
	always_comb begin
		st_d = st_q;
		st_d.rdata = 8'h00;
		if (req.wr && req.addr == MASTER_CLOCK_CONTROL_OFS) begin
			st_d.mclk_ctl = req.wdata;
		end
		if (req.wr && req.addr == CPU_CLOCK_DIVIDER_OFS) begin
			st_d.cpu_div = req.wdata[CPU_DIVIDER_W-1:0];
		end
		if (req.rd) begin
			unique case (req.addr)
				MASTER_CLOCK_CONTROL_OFS: st_d.rdata = st_q.mclk_ctl;
				CPU_CLOCK_DIVIDER_OFS: st_d.rdata = {2'h0, st_q.cpu_div};
				default: st_d.rdata = 8'h00;
			endcase
		end
		// Half period is field plus one master cycles, full period twice that
		if (st_q.mclk_ctl[FAST_OSC_DISABLE_BIT]) begin
			st_d.div_cnt = 6'h00;
		end else if (st_q.div_cnt >= st_q.cpu_div) begin
			st_d.div_cnt = 6'h00;
			st_d.cpu_clk = ~st_q.cpu_clk;
		end else begin
			st_d.div_cnt = st_q.div_cnt + 6'h01;
		end
		// Derived slow clock only runs while the slow oscillator is off
		if (!st_q.mclk_ctl[SLOW_OSC_DISABLE_BIT] || st_q.mclk_ctl[FAST_OSC_DISABLE_BIT]) begin
			st_d.slow_cnt = 16'h0000;
		end else if (st_q.slow_cnt >= SLOW_LAST) begin
			st_d.slow_cnt = 16'h0000;
			st_d.slow_clk = ~st_q.slow_clk;
		end else begin
			st_d.slow_cnt = st_q.slow_cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_q <= '{mclk_ctl: MASTER_CLOCK_CONTROL_RST, cpu_div: CPU_DIVIDER_FIELD_RST,
				div_cnt: 6'h00, cpu_clk: 1'b0, slow_cnt: 16'h0000, slow_clk: 1'b0,
				rdata: 8'h00};
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================
	// Outputs
	assign rdata = st_q.rdata;
	assign vco_ratio = {1'b0, mult, 1'b0} + 5'h04;
	assign fast_osc_off = st_q.mclk_ctl[FAST_OSC_DISABLE_BIT];
	// With the fast oscillator off nothing downstream can be clocked
	logic [2:0] gate_bits;
	logic [2:0] gate_en;
	assign gate_bits = st_q.mclk_ctl[KEYPAD_CLOCK_GATE_BIT:SERIAL_BUS_CLOCK_GATE_BIT];
	for (genvar g = 0; g < 3; g++) begin : g_gate
		assign gate_en[g] = !gate_bits[g] && !fast_osc_off;
	end
	assign keypad_clk_en = gate_en[2];
	assign card_clk_en = gate_en[1];
	assign serial_bus_clk_en = gate_en[0];
	assign slow_osc_run = !st_q.mclk_ctl[SLOW_OSC_DISABLE_BIT];
	assign slow_from_main = st_q.mclk_ctl[SLOW_OSC_DISABLE_BIT];
	assign slow_clk = st_q.slow_clk;
	assign cpu_clock = st_q.cpu_clk;
	assign core_clock_out_pin = st_q.cpu_clk;

	// ==========================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// ==========================================
	// Bus sequences
	sequence wr_mclk_s;
		req.wr && req.addr == MASTER_CLOCK_CONTROL_OFS;
	endsequence
	sequence wr_div_s;
		req.wr && req.addr == CPU_CLOCK_DIVIDER_OFS;
	endsequence
	sequence rd_mclk_s;
		req.rd && req.addr == MASTER_CLOCK_CONTROL_OFS;
	endsequence
	sequence rd_div_s;
		req.rd && req.addr == CPU_CLOCK_DIVIDER_OFS;
	endsequence
	sequence rd_other_s;
		req.rd && req.addr != MASTER_CLOCK_CONTROL_OFS && req.addr != CPU_CLOCK_DIVIDER_OFS;
	endsequence
	sequence no_rd_s;
		!req.rd;
	endsequence
	sequence no_wr_mclk_s;
		!(req.wr && req.addr == MASTER_CLOCK_CONTROL_OFS);
	endsequence
	sequence no_wr_div_s;
		!(req.wr && req.addr == CPU_CLOCK_DIVIDER_OFS);
	endsequence

	// ==========================================
	// Divider and slow clock sequences
	sequence div_due_s;
		!fast_osc_off && st_q.div_cnt >= st_q.cpu_div;
	endsequence
	sequence div_busy_s;
		!fast_osc_off && st_q.div_cnt < st_q.cpu_div;
	endsequence
	sequence slow_due_s;
		slow_from_main && !fast_osc_off && st_q.slow_cnt >= SLOW_LAST;
	endsequence
	sequence slow_busy_s;
		slow_from_main && !fast_osc_off && st_q.slow_cnt < SLOW_LAST;
	endsequence
	sequence slow_idle_s;
		!slow_from_main || fast_osc_off;
	endsequence

	// ==========================================
	// Registers and reset
	property reset_regs_p;
		$rose(rstn) |-> st_q.mclk_ctl == MASTER_CLOCK_CONTROL_RST
			&& st_q.cpu_div == CPU_DIVIDER_FIELD_RST;
	endproperty
	reset_value_a: assert property (reset_regs_p)
		else $error("reset values wrong");

	property reset_outs_p;
		$rose(rstn) |-> rdata == 8'h00 && !cpu_clock && !slow_clk;
	endproperty
	reset_outputs_a: assert property (reset_outs_p)
		else $error("outputs after reset wrong");

	property ratio_p;
		vco_ratio == 5'(2 * mult + 4);
	endproperty
	ratio_formula_a: assert property (ratio_p)
		else $error("vco ratio wrong");

	property ratio_range_p;
		mult != 3'h0 |-> vco_ratio >= 5'h06 && vco_ratio <= 5'h12;
	endproperty
	ratio_range_a: assert property (ratio_range_p)
		else $error("vco ratio out of range");

	property mclk_write_p;
		wr_mclk_s |=> st_q.mclk_ctl == $past(req.wdata);
	endproperty
	mclk_write_a: assert property (mclk_write_p)
		else $error("master register write lost");

	property mclk_hold_p;
		no_wr_mclk_s |=> $stable(st_q.mclk_ctl);
	endproperty
	mclk_hold_a: assert property (mclk_hold_p)
		else $error("master register changed unasked");

	property div_write_p;
		wr_div_s |=>
			st_q.cpu_div == $past(req.wdata[CPU_DIVIDER_W-1:0]);
	endproperty
	div_write_a: assert property (div_write_p)
		else $error("divider register write lost");

	property div_hold_p;
		no_wr_div_s |=> $stable(st_q.cpu_div);
	endproperty
	div_hold_a: assert property (div_hold_p)
		else $error("divider register changed unasked");

	// ==========================================
	// Clock gates
	property keypad_gate_p;
		wr_mclk_s ##0 !req.wdata[FAST_OSC_DISABLE_BIT]
			|=> keypad_clk_en == !$past(req.wdata[KEYPAD_CLOCK_GATE_BIT]);
	endproperty
	keypad_gate_a: assert property (keypad_gate_p)
		else $error("keypad gate wrong");

	property card_gate_p;
		wr_mclk_s ##0 !req.wdata[FAST_OSC_DISABLE_BIT]
			|=> card_clk_en == !$past(req.wdata[CARD_CLOCK_GATE_BIT]);
	endproperty
	card_gate_a: assert property (card_gate_p)
		else $error("card gate wrong");

	property bus_gate_p;
		wr_mclk_s ##0 !req.wdata[FAST_OSC_DISABLE_BIT]
			|=> serial_bus_clk_en == !$past(req.wdata[SERIAL_BUS_CLOCK_GATE_BIT]);
	endproperty
	bus_gate_a: assert property (bus_gate_p)
		else $error("serial bus gate wrong");

	property fast_gates_p;
		fast_osc_off |-> !keypad_clk_en && !card_clk_en && !serial_bus_clk_en;
	endproperty
	fast_off_gates_a: assert property (fast_gates_p)
		else $error("gates open with fast oscillator off");

	property fast_hold_p;
		fast_osc_off |=> $stable(cpu_clock) && $stable(slow_clk);
	endproperty
	fast_off_hold_a: assert property (fast_hold_p)
		else $error("clocks run with fast oscillator off");

	// ==========================================
	// Cpu divider
	property cpu_toggle_p;
		$changed(cpu_clock) |-> $past(!fast_osc_off)
			&& $past(st_q.div_cnt) >= $past(st_q.cpu_div);
	endproperty
	cpu_toggle_a: assert property (cpu_toggle_p)
		else $error("cpu clock edge early");

	property cpu_due_p;
		div_due_s |=> $changed(cpu_clock);
	endproperty
	cpu_due_a: assert property (cpu_due_p)
		else $error("cpu clock edge missing");

	property cpu_wait_p;
		div_busy_s |=> $stable(cpu_clock)
			&& st_q.div_cnt == $past(st_q.div_cnt) + 6'h01;
	endproperty
	cpu_wait_a: assert property (cpu_wait_p)
		else $error("cpu divider count wrong");

	// ==========================================
	// Read data
	property div_readback_p;
		rd_div_s |=> rdata == {2'h0, $past(st_q.cpu_div)};
	endproperty
	div_readback_a: assert property (div_readback_p)
		else $error("divider readback wrong");

	property div_upper_p;
		rd_div_s |=> rdata[7:6] == 2'h0;
	endproperty
	div_upper_zero_a: assert property (div_upper_p)
		else $error("divider upper bits not zero");

	property mclk_readback_p;
		rd_mclk_s |=> rdata == $past(st_q.mclk_ctl);
	endproperty
	mclk_readback_a: assert property (mclk_readback_p)
		else $error("master readback wrong");

	property other_read_p;
		rd_other_s |=> rdata == 8'h00;
	endproperty
	other_read_a: assert property (other_read_p)
		else $error("unmapped read not zero");

	property idle_read_p;
		no_rd_s |=> rdata == 8'h00;
	endproperty
	idle_read_a: assert property (idle_read_p)
		else $error("read data stands too long");

	// ==========================================
	// Slow clock and pin
	property slow_excl_p;
		slow_osc_run != slow_from_main;
	endproperty
	slow_exclusive_a: assert property (slow_excl_p)
		else $error("slow clock select wrong");

	property slow_hold_p;
		slow_idle_s |=> $stable(slow_clk);
	endproperty
	slow_hold_a: assert property (slow_hold_p)
		else $error("derived slow clock runs while unused");

	property slow_due_p;
		slow_due_s |=> $changed(slow_clk);
	endproperty
	slow_due_a: assert property (slow_due_p)
		else $error("slow clock edge missing");

	property slow_wait_p;
		slow_busy_s |=> $stable(slow_clk)
			&& st_q.slow_cnt == $past(st_q.slow_cnt) + 16'h0001;
	endproperty
	slow_wait_a: assert property (slow_wait_p)
		else $error("slow clock count wrong");

	property pin_p;
		core_clock_out_pin == cpu_clock;
	endproperty
	pin_follow_a: assert property (pin_p)
		else $error("cpu pin mismatch");
endmodule

// [ckg_crystal_model.sv]
// Purpose: crystal or external clock source on the far side of the block
// Assumes: frequency given in kHz by the bench
// Notes: reports the master clock that the loop ratio makes from it
`timescale 1ns/1ps
module ckg_crystal_model (
	input wire logic [4:0] vco_ratio,
	input wire logic [31:0] xtal_khz,
	output logic [31:0] master_khz
);
	// ==========================================
	// Loop output; the bench only offers crystals from the fitted table
	assign master_khz = 32'(vco_ratio) * xtal_khz;
endmodule

// [ckg_clock_control_bench.sv]
// Purpose: self-checking bench for ckg_clock_control
// Assumes: SLOW_HALF shortened to 4 so the slow clock is quick to measure
// Notes: fixed xorshift seed; expectations come from bench constants, inline expressions and the rat function
`timescale 1ns/1ps
module ckg_clock_control_bench;
	import ckg_pkg::*;
	logic clk = 0;
	logic rstn = 0;
	ckg_req_t req = '0;
	logic [7:0] rdata;
	logic [4:0] vco_ratio;
	logic fast_osc_off, keypad_clk_en, card_clk_en, serial_bus_clk_en;
	logic slow_osc_run, slow_from_main, slow_clk, cpu_clock, core_clock_out_pin;
	logic [31:0] xtal_khz = 12000;
	logic [31:0] master_khz;
	logic [31:0] seed = 32'hB732F288;
	logic [7:0] v;
	logic [5:0] d;
	int num_errors = 0;
	int compares = 0;
	int n;
	int xt[5] = '{12000, 9600, 8000, 6860, 6000};
	ckg_clock_control #(.SLOW_HALF(4)) DUT (.clk, .rstn, .req, .rdata, .vco_ratio,
		.fast_osc_off, .keypad_clk_en, .card_clk_en, .serial_bus_clk_en, .slow_osc_run,
		.slow_from_main, .slow_clk, .cpu_clock, .core_clock_out_pin);
	ckg_crystal_model xtal_src (.vco_ratio, .xtal_khz, .master_khz);
	initial forever #2.5 clk = ~clk;
	// ==========================================
	// Helpers
	function logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function logic [4:0] rat(input logic [2:0] m);
		return 5'(m) * 5'h02 + 5'h04;
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] dat);
		req.addr <= a;
		req.wdata <= dat;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] exp);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		@(negedge clk);
		chk(rdata, exp, "rdata");
		@(posedge clk);
	endtask
	// Measures the second half period, the first may be cut short by a rewrite
	task half(input bit s, output int c);
		logic v0;
		#1;
		for (int k = 0; k < 2; k++) begin
			v0 = s ? slow_clk : cpu_clock;
			c = 0;
			while (c < 300 && (s ? slow_clk : cpu_clock) === v0) begin
				@(posedge clk);
				#1;
				c++;
			end
		end
	endtask
	task complete_run;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		complete_run;
	end
	// ==========================================
	// Scenarios
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk(master_khz, 96000, "master");
		rd(MASTER_CLOCK_CONTROL_OFS, 8'h0A);
		rd(CPU_CLOCK_DIVIDER_OFS, 8'h0C);
		rd(16'h0090, 8'h00);
		half(0, n);
		chk(n, 13, "cpu half");
		for (int i = 0; i < 5; i++) begin
			xtal_khz <= xt[i];
			wr(MASTER_CLOCK_CONTROL_OFS, 8'(i + 2) | 8'h08);
			@(negedge clk);
			chk(master_khz / 100, 960, "master");
			@(posedge clk);
		end
		for (int i = 0; i < 16; i++) begin
			seed = xs(seed);
			v = {1'b0, seed[6:3], 3'(seed[10:8] % 7 + 1)};
			wr(MASTER_CLOCK_CONTROL_OFS, v);
			@(negedge clk);
			chk(vco_ratio, rat(v[2:0]), "ratio");
			chk({keypad_clk_en, card_clk_en, serial_bus_clk_en}, 3'(~v[6:4]), "gates");
			chk({slow_osc_run, slow_from_main}, {~v[3], v[3]}, "slow src");
			@(posedge clk);
			rd(MASTER_CLOCK_CONTROL_OFS, v);
		end
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			d = (i == 0) ? 6'h02 : (i == 1) ? 6'h3F : 6'(seed % 62 + 2);
			wr(CPU_CLOCK_DIVIDER_OFS, {2'h3, d});
			rd(CPU_CLOCK_DIVIDER_OFS, {2'h0, d});
			half(0, n);
			chk(n, d + 1, "cpu half");
			chk(core_clock_out_pin, cpu_clock, "pin");
		end
		wr(MASTER_CLOCK_CONTROL_OFS, 8'h0A);
		half(1, n);
		chk(n, 4, "slow half");
		wr(MASTER_CLOCK_CONTROL_OFS, 8'h02);
		@(negedge clk);
		v[0] = slow_clk;
		repeat (20) @(posedge clk);
		chk(slow_clk, v[0], "slow hold");
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(MASTER_CLOCK_CONTROL_OFS, 8'h0A);
		rd(CPU_CLOCK_DIVIDER_OFS, 8'h0C);
		wr(MASTER_CLOCK_CONTROL_OFS, 8'h8A);
		@(negedge clk);
		chk({fast_osc_off, keypad_clk_en, card_clk_en, serial_bus_clk_en}, 4'h8, "stop");
		v[0] = cpu_clock;
		repeat (30) @(posedge clk);
		chk(cpu_clock, v[0], "cpu hold");
		complete_run;
	end
endmodule
